// >>> hdl/esiu_core.v
// Function
// RQ1 - Call via working register pushes PC+2, then loads PC from working register and latches.
// RQ2 - That call replaces the low PC byte wholesale with the working register.
// RQ3 - Indexed-to-absolute move source is stack pointer plus 7-bit first-word offset.
// RQ4 - Indexed-to-absolute move destination is the 12-bit field of word two.
// RQ5 - Indexed-to-absolute move decodes as EBh with bit7 clear, word two top nibble Fh.
// RQ6 - Move addresses reach all of the 4096-byte data space.
// RQ7 - Software never targets PC low or return-top bytes with an indexed move.
// RQ8 - An indirect register as move source reads as 00h.
// RQ9 - Indexed-to-indexed move adds separate 7-bit offsets to stack pointer.
// RQ10 - Indexed-to-indexed move decodes as EBh with bit7 set, dest offset in word two.
// RQ11 - Indexed-to-indexed move with indirect destination does nothing.
// RQ12 - Literal push writes literal at stack pointer, then decrements pointer by one.
// RQ13 - Literal push decodes from top byte FAh and takes one cycle.
// RQ14 - Pointer subtract takes 6-bit literal from pointer 0, 1 or 2, no flags.
// RQ15 - Pointer subtract decodes from top byte E9h, select bits 7:6, literal 5:0.
// RQ16 - Select value 3 subtracts from stack pointer only, then returns.
// RQ17 - Subtract-and-return loads PC from return stack top.
// RQ18 - Subtract-and-return takes two cycles, second one idle during fetch redirect.
// RQ19 - Extension enable also enables indexed literal offset addressing.
// RQ20 - Extension off: access bit 0 selects access bank, 1 selects bank register.
// RQ21 - Extension on, access bit 0, operand up to 5Fh is stack pointer offset.
// RQ22 - Stack pointer zero maps indexed operands onto the original access addresses.
// RQ23 - Destination-select bit keeps its usual meaning in indexed mode.
// RQ24 - Extension stays off while the configuration enable bit is 0.
// RQ25 - A second instruction word with top nibble Fh reached directly does nothing; with the extension on, the core runs one with top byte FAh as a literal push.
`timescale 1ns/1ps
`include "esiu_defines.vh"

module esiu_core #(
	parameter AW  = 12,
	parameter PCW = 21
) (
	input  wire           CLK_I,
	input  wire           RST_B_I,
	input  wire           PSEL_I,
	input  wire           PENABLE_I,
	input  wire           PWRITE_I,
	input  wire [7:0]     PADDR_I,
	input  wire [31:0]    PWDATA_I,
	output reg  [31:0]    PRDATA_O,
	output reg            PREADY_O,
	output reg            PSLVERR_O,
	input  wire           EXT_CFG_I,
	input  wire           INSTR_VALID_I,
	input  wire [15:0]    INSTR_I,
	input  wire [PCW-1:0] PC_I,
	input  wire [3:0]     BANK_SELECT_I,
	input  wire [PCW-1:0] RETURN_TOP_I,
	input  wire [7:0]     DMEM_RDATA_I,
	output reg            BUSY_O,
	output reg  [AW-1:0]  DMEM_ADDR_O,
	output reg            DMEM_RD_O,
	output reg            DMEM_WR_O,
	output reg  [7:0]     DMEM_WDATA_O,
	output reg            RSTACK_PUSH_O,
	output reg  [PCW-1:0] RSTACK_DATA_O,
	output reg            RSTACK_POP_O,
	output reg            PC_LOAD_O,
	output reg  [PCW-1:0] PC_TARGET_O,
	output reg            OPER_VALID_O,
	output reg  [AW-1:0]  OPER_ADDR_O,
	output reg            OPER_DEST_REG_O
);

	localparam [2:0] S_IDLE  = 3'd0;
	localparam [2:0] S_WORD2 = 3'd1;
	localparam [2:0] S_READ  = 3'd2;
	localparam [2:0] S_WRITE = 3'd3;
	localparam [2:0] S_NOP   = 3'd4;

	reg  [2:0]    state_r;
	reg  [2:0]    cfg_sync_r;
	reg           cfg_ok_r;
	reg           ext_allow_r;
	reg  [AW-1:0] ptr0_r;
	reg  [AW-1:0] ptr1_r;
	reg  [AW-1:0] ssp_r;
	reg  [7:0]    working_register_r;
	reg  [7:0]    hi_latch_r;
	reg  [4:0]    up_latch_r;
	reg           move_indexed_to_indexed_r;
	reg  [AW-1:0] src_r;
	reg           src_ind_r;
	reg           dst_ind_r;
	reg  [AW-1:0] dst_r;
	reg  [31:0]   rdata_nxt;
	reg           addr_ok_nxt;

	wire          ext_en;
	wire          take;
	wire          apb_wr;
	wire [AW-1:0] idx_addr;
	wire          idx_ind;
	wire [7:0]    op_hi;
	wire [1:0]    psub_sel;
	wire [AW-1:0] psub_k;

	assign ext_en   = cfg_ok_r & ext_allow_r; // [RQ24] [RQ19]
	assign take     = INSTR_VALID_I & (state_r == S_IDLE | state_r == S_WORD2);
	assign apb_wr   = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
	assign op_hi    = INSTR_I[15:8];
	assign psub_sel = INSTR_I[7:6];
	assign psub_k   = {{(AW-6){1'b0}}, INSTR_I[5:0]};

	esiu_addr_calc #(
		.AW(AW)
	) u_idx (
		.base_i     (ssp_r),
		.offset_i   (INSTR_I[6:0]),
		.addr_o     (idx_addr),
		.indirect_o (idx_ind)
	);

	function is_file_op;
		input [15:0] w;
		begin
			is_file_op = (w[15:12] >= `ESIU_FILE_OP_LO) && (w[15:12] <= `ESIU_FILE_OP_HI);
		end
	endfunction

	// Operand address of a standard byte or bit instruction
	function [AW-1:0] oper_addr;
		input [15:0]   w;
		input          ext;
		input [AW-1:0] idx;
		input [3:0]    bank;
		begin
			if (w[8]) begin
				oper_addr = {bank, w[7:0]}; // [RQ20]
			end else if (ext && w[7:0] <= `ESIU_ACC_LIMIT) begin
				oper_addr = idx; // [RQ21] [RQ22]
			end else if (w[7:0] <= `ESIU_ACC_LIMIT) begin
				oper_addr = {`ESIU_ACC_LOW_PAGE, w[7:0]}; // [RQ20]
			end else begin
				oper_addr = {`ESIU_ACC_HIGH_PAGE, w[7:0]};
			end
		end
	endfunction

	always @* begin
		rdata_nxt   = 32'h00000000;
		addr_ok_nxt = 1'b1;
		case (PADDR_I)
			`ESIU_REG_CTRL: begin
				rdata_nxt[`ESIU_CTRL_EXT_BIT] = ext_allow_r;
			end
			`ESIU_REG_PTR0: begin
				rdata_nxt[AW-1:0] = ptr0_r;
			end
			`ESIU_REG_PTR1: begin
				rdata_nxt[AW-1:0] = ptr1_r;
			end
			`ESIU_REG_SSP: begin
				rdata_nxt[AW-1:0] = ssp_r;
			end
			`ESIU_REG_WORKING_REGISTER: begin
				rdata_nxt[7:0] = working_register_r;
			end
			`ESIU_REG_LATCH: begin
				rdata_nxt[`ESIU_LATCH_HI_LSB +: 8] = hi_latch_r;
				rdata_nxt[`ESIU_LATCH_UP_LSB +: 5] = up_latch_r;
			end
			`ESIU_REG_STATUS: begin
				rdata_nxt[2:0] = state_r;
				rdata_nxt[4]   = ext_en;
				rdata_nxt[5]   = cfg_ok_r;
			end
			default: begin
				addr_ok_nxt = 1'b0;
			end
		endcase
	end

	// Configuration pin: three flops, accepted when last two agree
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cfg_sync_r <= 3'h0;
			cfg_ok_r   <= 1'b0;
		end else begin
			cfg_sync_r <= {cfg_sync_r[1:0], EXT_CFG_I};
			if (cfg_sync_r[1] == cfg_sync_r[2]) begin
				cfg_ok_r <= cfg_sync_r[2];
			end
		end
	end

	// APB slave, no wait states
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			PREADY_O  <= 1'b0;
			PRDATA_O  <= 32'h00000000;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O  <= PSEL_I & ~PENABLE_I;
			if (PSEL_I & ~PENABLE_I) begin
				PRDATA_O  <= PWRITE_I ? 32'h00000000 : rdata_nxt;
				PSLVERR_O <= ~addr_ok_nxt;
			end else begin
				PSLVERR_O <= 1'b0;
			end
		end
	end

	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_r         <= S_IDLE;
			ext_allow_r     <= `ESIU_RST_CTRL;
			ptr0_r          <= `ESIU_RST_PTR;
			ptr1_r          <= `ESIU_RST_PTR;
			ssp_r           <= `ESIU_RST_PTR;
			working_register_r          <= `ESIU_RST_BYTE;
			hi_latch_r      <= `ESIU_RST_BYTE;
			up_latch_r      <= `ESIU_RST_UPPER;
			move_indexed_to_indexed_r         <= 1'b0;
			src_r           <= `ESIU_RST_PTR;
			src_ind_r       <= 1'b0;
			dst_ind_r       <= 1'b0;
			dst_r           <= `ESIU_RST_PTR;
			BUSY_O          <= 1'b0;
			DMEM_ADDR_O     <= `ESIU_RST_PTR;
			DMEM_RD_O       <= 1'b0;
			DMEM_WR_O       <= 1'b0;
			DMEM_WDATA_O    <= `ESIU_RST_BYTE;
			RSTACK_PUSH_O   <= 1'b0;
			RSTACK_DATA_O   <= {PCW{1'b0}};
			RSTACK_POP_O    <= 1'b0;
			PC_LOAD_O       <= 1'b0;
			PC_TARGET_O     <= {PCW{1'b0}};
			OPER_VALID_O    <= 1'b0;
			OPER_ADDR_O     <= `ESIU_RST_PTR;
			OPER_DEST_REG_O <= 1'b0;
		end else begin
			DMEM_RD_O     <= 1'b0;
			DMEM_WR_O     <= 1'b0;
			RSTACK_PUSH_O <= 1'b0;
			RSTACK_POP_O  <= 1'b0;
			PC_LOAD_O     <= 1'b0;
			OPER_VALID_O  <= 1'b0;
			BUSY_O        <= 1'b0;

			// Software writes; instruction updates below take priority
			if (apb_wr) begin
				case (PADDR_I)
					`ESIU_REG_CTRL: begin
						ext_allow_r <= PWDATA_I[`ESIU_CTRL_EXT_BIT];
					end
					`ESIU_REG_PTR0: begin
						ptr0_r <= PWDATA_I[AW-1:0];
					end
					`ESIU_REG_PTR1: begin
						ptr1_r <= PWDATA_I[AW-1:0];
					end
					`ESIU_REG_SSP: begin
						ssp_r <= PWDATA_I[AW-1:0];
					end
					`ESIU_REG_WORKING_REGISTER: begin
						working_register_r <= PWDATA_I[7:0];
					end
					`ESIU_REG_LATCH: begin
						hi_latch_r <= PWDATA_I[`ESIU_LATCH_HI_LSB +: 8];
						up_latch_r <= PWDATA_I[`ESIU_LATCH_UP_LSB +: 5];
					end
					default: begin
					end
				endcase
			end

			case (state_r)
				S_IDLE: begin
					if (take) begin
						if (ext_en && op_hi == `ESIU_OP_MOVS) begin
							move_indexed_to_indexed_r   <= INSTR_I[7]; // [RQ5] [RQ10]
							src_r     <= idx_addr; // [RQ3] [RQ9] [RQ6]
							src_ind_r <= idx_ind;
							state_r   <= S_WORD2;
						end else if (ext_en && op_hi == `ESIU_OP_PUSH_LITERAL) begin
							DMEM_ADDR_O  <= ssp_r; // [RQ12] [RQ13]
							DMEM_WDATA_O <= INSTR_I[7:0];
							DMEM_WR_O    <= 1'b1;
							ssp_r        <= ssp_r - {{(AW-1){1'b0}}, 1'b1};
						end else if (ext_en && INSTR_I[15:12] == `ESIU_NIB_WORD2) begin
							state_r <= S_IDLE; // [RQ25]
						end else if (ext_en && op_hi == `ESIU_OP_PSUB) begin
							case (psub_sel) // [RQ14] [RQ15]
								2'h0: begin
									ptr0_r <= ptr0_r - psub_k;
								end
								2'h1: begin
									ptr1_r <= ptr1_r - psub_k;
								end
								2'h2: begin
									ssp_r <= ssp_r - psub_k;
								end
								default: begin
									ssp_r        <= ssp_r - psub_k; // [RQ16]
									RSTACK_POP_O <= 1'b1;
									PC_LOAD_O    <= 1'b1;
									PC_TARGET_O  <= RETURN_TOP_I; // [RQ17]
									BUSY_O       <= 1'b1;
									state_r      <= S_NOP; // [RQ18]
								end
							endcase
						end else if (ext_en && INSTR_I == `ESIU_OP_CALL_VIA_WORKING_REG) begin
							RSTACK_PUSH_O <= 1'b1; // [RQ1]
							RSTACK_DATA_O <= PC_I + `ESIU_PC_STEP;
							PC_LOAD_O     <= 1'b1;
							PC_TARGET_O   <= {up_latch_r, hi_latch_r, working_register_r}; // [RQ2]
							BUSY_O        <= 1'b1;
							state_r       <= S_NOP;
						end else if (is_file_op(INSTR_I)) begin
							OPER_VALID_O    <= 1'b1;
							OPER_ADDR_O     <= oper_addr(INSTR_I, ext_en, idx_addr, BANK_SELECT_I);
							OPER_DEST_REG_O <= INSTR_I[9]; // [RQ23]
						end
					end
				end
				S_WORD2: begin
					if (INSTR_VALID_I) begin
						if (move_indexed_to_indexed_r) begin
							dst_r     <= idx_addr; // [RQ9]
							dst_ind_r <= idx_ind;
						end else begin
							dst_r     <= INSTR_I[AW-1:0]; // [RQ4] [RQ6]
							dst_ind_r <= 1'b0;
						end
						DMEM_ADDR_O <= src_r;
						DMEM_RD_O   <= ~src_ind_r;
						BUSY_O      <= 1'b1;
						state_r     <= S_READ;
					end
				end
				S_READ: begin
					BUSY_O  <= 1'b1;
					state_r <= S_WRITE;
				end
				S_WRITE: begin
					DMEM_ADDR_O  <= dst_r;
					DMEM_WDATA_O <= src_ind_r ? 8'h00 : DMEM_RDATA_I; // [RQ8]
					DMEM_WR_O    <= ~(move_indexed_to_indexed_r & dst_ind_r); // [RQ11]
					state_r      <= S_IDLE;
				end
				S_NOP: begin
					state_r <= S_IDLE;
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

endmodule // esiu_core

// >>> hdl/esiu_defines.vh
`ifndef ESIU_DEFINES_VH
`define ESIU_DEFINES_VH

// Register byte offsets
`define ESIU_REG_CTRL      8'h00
`define ESIU_REG_PTR0      8'h04
`define ESIU_REG_PTR1      8'h08
`define ESIU_REG_SSP       8'h0C
`define ESIU_REG_WORKING_REGISTER      8'h10
`define ESIU_REG_LATCH     8'h14
`define ESIU_REG_STATUS    8'h18

// Field positions
`define ESIU_CTRL_EXT_BIT  0
`define ESIU_LATCH_HI_LSB  0
`define ESIU_LATCH_UP_LSB  8

// Reset values
`define ESIU_RST_CTRL      1'h1
`define ESIU_RST_PTR       12'h000
`define ESIU_RST_BYTE      8'h00
`define ESIU_RST_UPPER     5'h00

// Opcode fields
`define ESIU_OP_MOVS       8'hEB
`define ESIU_OP_PUSH_LITERAL      8'hFA
`define ESIU_OP_PSUB       8'hE9
`define ESIU_OP_CALL_VIA_WORKING_REG      16'h0014
`define ESIU_NIB_WORD2     4'hF
`define ESIU_SEL_SSP       2'h3
`define ESIU_FILE_OP_LO    4'h1
`define ESIU_FILE_OP_HI    4'hB

// Access bank layout
`define ESIU_ACC_LIMIT     8'h5F
`define ESIU_ACC_HIGH_PAGE 4'hF
`define ESIU_ACC_LOW_PAGE  4'h0
`define ESIU_PC_STEP       21'h000002

// Indirect addressing register windows
`define ESIU_IND0_BASE     12'hFD0
`define ESIU_IND1_BASE     12'hFD8
`define ESIU_IND2_BASE     12'hFE0
`define ESIU_IND_SPAN      12'h005

`endif

// >>> hdl/esiu_addr_calc.v
`timescale 1ns/1ps
`include "esiu_defines.vh"

module esiu_addr_calc #(
	parameter AW = 12
) (
	input  wire [AW-1:0] base_i,
	input  wire [6:0]    offset_i,
	output wire [AW-1:0] addr_o,
	output wire          indirect_o
);

	function in_win;
		input [AW-1:0] a;
		input [AW-1:0] b;
		begin
			in_win = (a >= b) && (a < b + `ESIU_IND_SPAN);
		end
	endfunction

	// Wraps inside the data space so any location is reachable
	assign addr_o     = base_i + {{(AW-7){1'b0}}, offset_i};
	assign indirect_o = in_win(addr_o, `ESIU_IND0_BASE) | in_win(addr_o, `ESIU_IND1_BASE) |
		in_win(addr_o, `ESIU_IND2_BASE);

endmodule // esiu_addr_calc

// >>> test/esiu_dmem_model.sv
`timescale 1ns/1ps
module esiu_dmem_model (
	input  logic       clk_i,
	input  logic       rd_i,
	input  logic       wr_i,
	input  logic [11:0] addr_i,
	input  logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:4095];
	initial rdata_o = 8'h00;
	// Read data valid one cycle, then toggles so stale data never matches
	always @(posedge clk_i) begin
		if (wr_i) mem[addr_i] <= wdata_i;
		rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
	end
endmodule // esiu_dmem_model

// >>> test/esiu_core_sva.sv
`timescale 1ns/1ps
module esiu_core_sva #(
	parameter AW  = 12,
	parameter PCW = 21
) (
	input logic           CLK_I,
	input logic           RST_B_I,
	input logic           PSEL_I,
	input logic           PENABLE_I,
	input logic [7:0]     PADDR_I,
	input logic           PREADY_O,
	input logic           PSLVERR_O,
	input logic           INSTR_VALID_I,
	input logic [15:0]    INSTR_I,
	input logic [PCW-1:0] PC_I,
	input logic [3:0]     BANK_SELECT_I,
	input logic [PCW-1:0] RETURN_TOP_I,
	input logic           BUSY_O,
	input logic           DMEM_WR_O,
	input logic [7:0]     DMEM_WDATA_O,
	input logic           RSTACK_PUSH_O,
	input logic [PCW-1:0] RSTACK_DATA_O,
	input logic           RSTACK_POP_O,
	input logic           PC_LOAD_O,
	input logic [PCW-1:0] PC_TARGET_O,
	input logic           OPER_VALID_O,
	input logic [AW-1:0]  OPER_ADDR_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	wire tk = INSTR_VALID_I && !BUSY_O;
	wire fop = INSTR_I[15:12] >= 4'h1 && INSTR_I[15:12] <= 4'hB;
	logic w2_r;
	// Second word of a move is not a fresh instruction
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) w2_r <= 1'b0;
		else if (tk) w2_r <= !w2_r && INSTR_I[15:8] == 8'hEB;
	end
	wire t1 = tk && !w2_r;
	sequence s_push; t1 && INSTR_I[15:8] == 8'hFA; endsequence
	sequence s_call; t1 && INSTR_I == 16'h0014; endsequence
	sequence s_sub; t1 && INSTR_I[15:8] == 8'hE9; endsequence
	sequence s_fop; t1 && fop; endsequence
	a_push_data: assert property (s_push ##1 DMEM_WR_O |->
		DMEM_WDATA_O == $past(INSTR_I[7:0])) else $error("push literal wrong");
	a_push_fast: assert property (s_push |=> !BUSY_O) else $error("push not single cycle");
	a_call_link: assert property (s_call ##1 PC_LOAD_O |->
		RSTACK_PUSH_O && RSTACK_DATA_O == $past(PC_I) + 21'h2) else $error("call link wrong");
	a_sub_plain: assert property (s_sub ##0 INSTR_I[7:6] != 2'h3 |->
		##1 !PC_LOAD_O && !BUSY_O) else $error("pointer subtract not single cycle");
	a_sub_ret: assert property (s_sub ##1 RSTACK_POP_O |-> PC_LOAD_O && BUSY_O &&
		PC_TARGET_O == $past(RETURN_TOP_I) ##1 !PC_LOAD_O) else $error("return wrong");
	a_apb_wait: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("ready late");
	a_apb_once: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
	a_apb_err: assert property (PREADY_O |-> PSLVERR_O == (PADDR_I > 8'h18 || PADDR_I[1:0] != 2'h0))
		else $error("slave error wrong");
	a_oper_bank: assert property (s_fop ##0 INSTR_I[8] |=> OPER_VALID_O &&
		OPER_ADDR_O == {$past(BANK_SELECT_I), $past(INSTR_I[7:0])}) else $error("bank operand wrong");
	a_oper_high: assert property (s_fop ##0 !INSTR_I[8] && INSTR_I[7:0] > 8'h5F |=>
		OPER_ADDR_O == {4'hF, $past(INSTR_I[7:0])}) else $error("high access operand wrong");
endmodule // esiu_core_sva
bind esiu_core esiu_core_sva #(.AW(AW), .PCW(PCW)) u_sva (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I), .PC_I(PC_I),
	.BANK_SELECT_I(BANK_SELECT_I), .RETURN_TOP_I(RETURN_TOP_I), .BUSY_O(BUSY_O),
	.DMEM_WR_O(DMEM_WR_O), .DMEM_WDATA_O(DMEM_WDATA_O), .RSTACK_PUSH_O(RSTACK_PUSH_O),
	.RSTACK_DATA_O(RSTACK_DATA_O), .RSTACK_POP_O(RSTACK_POP_O), .PC_LOAD_O(PC_LOAD_O),
	.PC_TARGET_O(PC_TARGET_O), .OPER_VALID_O(OPER_VALID_O), .OPER_ADDR_O(OPER_ADDR_O));

// >>> test/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_top;
	logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, ext = 1, vld = 0, er;
	logic [7:0]  paddr = 0, k, v;
	logic [31:0] pwd = 0, rd;
	logic [15:0] ins = 0, w;
	logic [20:0] pc = 0, rtop = 0;
	logic [3:0]  bank = 0;
	logic [11:0] s, d, e;
	logic [12:0] l;
	wire  [31:0] prd;
	wire         prdy, perr, busy, drd, dwr, pld, push, pop, ov, odst;
	wire  [11:0] dadr, oadr;
	wire  [7:0]  dwd, drdat;
	wire  [20:0] rdat, ptgt;
	int n_mismatch = 0, compares = 0, nwr = 0, nw0;
	esiu_core dut (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
		.EXT_CFG_I(ext), .INSTR_VALID_I(vld), .INSTR_I(ins), .PC_I(pc), .BANK_SELECT_I(bank),
		.RETURN_TOP_I(rtop), .DMEM_RDATA_I(drdat), .BUSY_O(busy), .DMEM_ADDR_O(dadr), .DMEM_RD_O(drd),
		.DMEM_WR_O(dwr), .DMEM_WDATA_O(dwd), .RSTACK_PUSH_O(push), .RSTACK_DATA_O(rdat),
		.RSTACK_POP_O(pop), .PC_LOAD_O(pld), .PC_TARGET_O(ptgt), .OPER_VALID_O(ov),
		.OPER_ADDR_O(oadr), .OPER_DEST_REG_O(odst));
	esiu_dmem_model u_mem (.clk_i(clk), .rd_i(drd), .wr_i(dwr), .addr_i(dadr), .wdata_i(dwd), .rdata_o(drdat));
	initial forever #20 clk = ~clk;
	always @(posedge clk) if (dwr === 1'b1) nwr++;
	task finish_test;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task apb(input bit wr, input [7:0] a, input [31:0] dt);
		int i;
		psel <= 1; pwr <= wr; paddr <= a; pwd <= dt; @(posedge clk);
		pen <= 1; i = 0;
		do begin @(posedge clk); i++; end while (prdy !== 1'b1 && i < 20);
		if (prdy !== 1'b1) begin n_mismatch++; finish_test; end
		rd = prd; er = perr; psel <= 0; pen <= 0; @(posedge clk);
	endtask
	task run(input [15:0] w1, input [15:0] w2, input bit two);
		int i;
		vld <= 1; ins <= w1; pc <= $urandom; rtop <= $urandom; bank <= $urandom; @(posedge clk);
		if (two) begin ins <= w2; @(posedge clk); end
		vld <= 0; i = 0;
		do begin @(posedge clk); i++; end while (busy !== 1'b0 && i < 20);
		if (busy !== 1'b0) begin n_mismatch++; finish_test; end
		repeat (2) @(posedge clk);
	endtask
	function [11:0] oper(input bit en, input [15:0] op, input [11:0] sp, input [3:0] b);
		oper = op[8] ? {b, op[7:0]} : (en && op[7:0] <= 8'h5F) ? sp + op[7:0] :
			{(op[7:0] <= 8'h5F) ? 4'h0 : 4'hF, op[7:0]};
	endfunction
	initial begin
		k = $urandom(32'h44111257);
		repeat (20) @(posedge clk);
		rst_b <= 1; repeat (2) @(posedge clk);
		apb(0, 8'h00, 0); `CHK("ctrl reset", 32'h1, rd)
		apb(0, 8'h1C, 0); `CHK("unmapped", 1'b1, er)
		for (int j = 0; j < 4; j++) begin
			s = j == 0 ? 12'h000 : $urandom; k = $urandom;
			apb(1, 8'h0C, s); run({8'hFA, k}, 0, 0);
			`CHK("push data", k, u_mem.mem[s])
			apb(0, 8'h0C, 0); `CHK("push ssp", {20'h0, s - 12'h1}, rd)
		end
		for (int j = 0; j < 4; j++) begin
			s = $urandom; k = $urandom % 64; v = j == 0 ? 8'h04 : j == 1 ? 8'h08 : 8'h0C;
			apb(1, v, s); run({8'hE9, j[1:0], k[5:0]}, 0, 0);
			apb(0, v, 0); `CHK("ptr sub", {20'h0, s - k[5:0]}, rd)
			if (j == 3) `CHK("ret target", rtop, ptgt)
		end
		for (int j = 0; j < 4; j++) begin
			s = $urandom % 12'hF00; k = $urandom % 64; d = $urandom % 12'hF00; v = $urandom;
			if (j == 1) s = 12'hFD0 - k;
			if (j == 3) begin s = 12'hF80; d = 12'h058; end
			e = j < 2 ? d : s + d[6:0];
			u_mem.mem[e] = 8'hC3; u_mem.mem[s + k] = v;
			apb(1, 8'h0C, s);
			run({8'hEB, j[1], k[6:0]}, j < 2 ? {4'hF, d} : {9'h1F5, d[6:0]}, 1);
			`CHK("move dst", j == 1 ? 8'h00 : j == 3 ? 8'hC3 : v, u_mem.mem[e])
		end
		k = $urandom; l = $urandom;
		apb(1, 8'h10, k); apb(1, 8'h14, l); run(16'h0014, 0, 0);
		`CHK("call ret", pc + 21'h2, rdat)
		`CHK("call pc", {l[12:8], l[7:0], k}, ptgt)
		for (int j = 0; j < 16; j++) begin
			s = j[0] ? 12'h000 : $urandom;
			w = {6'b001001, 1'($urandom), j[1], j[2] ? 8'(8'h60 + j) : 8'(8'h5F - j)};
			apb(1, 8'h00, !j[3]); apb(1, 8'h0C, s); run(w, 0, 0);
			`CHK("oper addr", oper(!j[3], w, s, bank), oadr)
			`CHK("oper dest", w[9], odst)
		end
		nw0 = nwr; run(16'hFA55, 0, 0); apb(1, 8'h00, 1);
		ext <= 0; repeat (6) @(posedge clk); run(16'hFA55, 0, 0);
		`CHK("ext off writes", nw0, nwr)
		ext <= 1; repeat (6) @(posedge clk); run(16'hF123, 0, 0);
		`CHK("lone word2 writes", nw0, nwr)
		finish_test;
	end
endmodule // tb_top
